// ===== logic/angle_sensor_defs.vh
// Purpose: Shared offsets, field positions, reset values and counts
// Assumes: Included by the register map and its helpers
// Notes:   Offsets are 14-bit frame addresses
`ifndef ANGLE_SENSOR_DEFS_VH
`define ANGLE_SENSOR_DEFS_VH
`define ADDR_IDLE       14'h0000
`define ADDR_ERRORS     14'h0001
`define ADDR_FUSE_CTRL  14'h0003
`define ADDR_ZERO_HI    14'h0016
`define ADDR_ZERO_LO    14'h0017
`define ADDR_CFG_ONE    14'h0018
`define ADDR_CFG_TWO    14'h0019
`define ADDR_REPAIR     14'h001a
`define ADDR_DIAG       14'h3ffc
`define ADDR_FIELD      14'h3ffd
`define ADDR_RAW_ANG    14'h3ffe
`define ADDR_TOP_ANG    14'h3fff
`define ERR_PARITY_BIT  2
`define ERR_ADDR_BIT    1
`define ERR_FRAME_BIT   0
`define FUSE_ACCESS_BIT 0
`define FUSE_RELOAD_BIT 2
`define FUSE_BURN_BIT   3
`define FUSE_VERIFY_BIT 6
`define CFG_INDEX_PULSE_WIDTH_BIT  0
`define CFG_NOISE_BIT   1
`define CFG_DIR_BIT     2
`define CFG_PWMPIN_BIT  3
`define CFG_SPDDIS_BIT  4
`define CFG_TOPSEL_BIT  6
`define CFG_PWMEN_BIT   7
`define ZLO_STRONG_BIT  6
`define ZLO_WEAK_BIT    7
`define DIAG_RST        14'h0180
`define CFG_ONE_RST     8'h01
`define GAIN_MAX        8'hff
`define GAIN_MIN        8'h00
`define NV_LAST         3'h4
`define FRAME_BITS      5'h10
`define FRAME_RD_BIT    14
`endif

// ===== logic/fuse_store.v
// Purpose: One-time fuse array holding the five non-volatile words
// Assumes: por models the blank fuse state; srst never touches it
// Notes:   Read data registered; writes refused once the last word burns
`timescale 1ns/1ps
`include "angle_sensor_defs.vh"
module fuse_store (
  input  wire       core_clk,
  input  wire       por,
  input  wire       we,
  input  wire [2:0] waddr,
  input  wire [7:0] wdata,
  input  wire [2:0] raddr,
  output reg  [7:0] rdata_r,
  output reg        locked_r
);
  reg [7:0] mem [0:4];
  integer   i;

  always @(posedge core_clk)
  begin
    if (por)
    begin
      for (i = 0; i < 5; i = i + 1)
        mem[i] <= 8'h00;
      locked_r <= 1'b0;
      rdata_r  <= 8'h00;
    end
    else
    begin
      // Burn once only; later burns leave the array as it is
      if (we && !locked_r)
      begin
        mem[waddr] <= wdata;
        if (waddr == `NV_LAST)
          locked_r <= 1'b1;
      end
      rdata_r <= mem[raddr];
    end
  end
endmodule // fuse_store

// ===== logic/spi_frame_rx.v
// Purpose: Synchronise the serial pins and collect one frame
// Assumes: Serial clock far slower than core_clk (mode 1, MSB first)
// Notes:   All pulses are one core cycle wide
`timescale 1ns/1ps
`include "angle_sensor_defs.vh"
module spi_frame_rx (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        sclk_pin,
  input  wire        csn_pin,
  input  wire        mosi_pin,
  output reg         frame_start_r,
  output reg         sclk_rise_r,
  output reg         frame_done_r,
  output reg         frame_len_ok_r,
  output reg  [15:0] frame_word_r
);
  wire [2:0] pins_w = {mosi_pin, csn_pin, sclk_pin};
  reg  [2:0] meta_r;
  reg  [2:0] sync_r;
  reg  [2:0] prev_r;
  reg  [4:0] cnt_r;
  genvar     g;

  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_sync
      always @(posedge core_clk)
      begin
        if (srst)
        begin
          meta_r[g] <= (g == 1);
          sync_r[g] <= (g == 1);
        end
        else
        begin
          meta_r[g] <= pins_w[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  wire sel_w  = ~sync_r[1];
  wire fall_w = prev_r[0] & ~sync_r[0];
  wire rise_w = ~prev_r[0] & sync_r[0];

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      prev_r         <= 3'h2;
      cnt_r          <= 5'h00;
      frame_start_r  <= 1'b0;
      sclk_rise_r    <= 1'b0;
      frame_done_r   <= 1'b0;
      frame_len_ok_r <= 1'b0;
      frame_word_r   <= 16'h0000;
    end
    else
    begin
      prev_r         <= sync_r;
      frame_start_r  <= prev_r[1] & ~sync_r[1];
      frame_done_r   <= ~prev_r[1] & sync_r[1];
      sclk_rise_r    <= sel_w & rise_w;
      frame_len_ok_r <= (cnt_r == `FRAME_BITS);
      if (prev_r[1] & ~sync_r[1])
        cnt_r <= 5'h00;
      else if (sel_w & fall_w)
      begin
        // Count saturates so long frames still read as wrong length
        frame_word_r <= {frame_word_r[14:0], sync_r[2]};
        if (cnt_r != 5'h1f)
          cnt_r <= cnt_r + 5'h01;
      end
    end
  end
endmodule // spi_frame_rx

// ===== logic/angle_sensor_register_map.v
// Purpose: Register map of the angle sensor behind its serial slave port
// Assumes: Sensor core values arrive on core_clk; pins are asynchronous
// Notes:   Commands act at the end of frame; answers go out next frame
// Summary of operation
// [RQ1] Fourteen-bit address in every command frame
// [RQ2] Reading address zero changes nothing
// [RQ3] Error flags: parity, bad address, framing
// [RQ4] Error register clears after being read
// [RQ5] Fuse access enable; burn start bit
// [RQ6] Reload from fuses; verify mode bit
// [RQ7] Weak field at gain max, strong at zero
// [RQ8] Loops-done bit shows offset settling finished
// [RQ9] Diagnostics: gain, overflow; reset 0x0180
// [RQ10] Raw and compensated angle, read only
// [RQ11] Config bit six picks top-address angle
// [RQ12] Soft writes act now; reset restores
// [RQ13] Fuses burn once and persist
// [RQ14] Defaults zero, first config word one
// [RQ15] Zero position split high eight, low six
// [RQ16] Low zero word bits enable field errors
// [RQ17] Index width, noise, direction, speed compensation
// [RQ18] PWM enable and output pin choice
// [RQ19] Pole pairs code plus one, max seven
// [RQ20] Hysteresis code maps three down to zero
// [RQ21] Incremental resolution twelve, eleven, ten bits
// [RQ22] Repair code forces one fuse bit high
// [RQ23] Frame: parity, read flag, address
// [RQ24] Execute at select rise, answer next frame
// [RQ25] Answer carries parity and error bit
// [RQ26] Writes to read-only registers ignored
// [RQ27] Unmapped addresses flag bad address
`timescale 1ns/1ps
`include "angle_sensor_defs.vh"
module angle_sensor_register_map (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        por,
  input  wire        sclk_pin,
  input  wire        csn_pin,
  input  wire        mosi_pin,
  input  wire [13:0] raw_angle,
  input  wire [13:0] compensated_angle,
  input  wire [13:0] magnitude_value,
  input  wire [7:0]  gain_value,
  input  wire        angle_overflow_flag,
  input  wire        offset_loops_done,
  output reg         miso_out_r,
  output reg         miso_oe_n_r,
  output reg  [13:0] zero_position_r,
  output reg  [1:0]  index_pulse_width_r,
  output reg         low_noise_trade_r,
  output reg         rotation_invert_r,
  output reg         pwm_pin_select_r,
  output reg         speed_comp_disable_r,
  output reg         pwm_output_enable_r,
  output reg  [2:0]  pole_pair_count_r,
  output reg  [1:0]  dead_band_select_r,
  output reg  [3:0]  incremental_resolution_r,
  output reg         field_error_flag_r,
  output reg         otp_access_enable_r,
  output reg         otp_verify_r,
  output wire        fuse_burned
);
  localparam ST_IDLE = 2'd0;
  localparam ST_LOAD = 2'd1;
  localparam ST_BURN = 2'd2;

  wire        frame_start;
  wire        sclk_rise;
  wire        frame_done;
  wire        len_ok;
  wire [15:0] fw;
  wire [7:0]  fuse_rdata;
  wire [31:0] eff_w;

  reg  [2:0]  err_r;
  reg         cmd_err_r;
  reg         expect_data_r;
  reg  [13:0] wr_addr_r;
  reg         pend_r;
  reg  [13:0] resp_addr_r;
  reg  [15:0] resp_r;
  reg  [15:0] tx_shift_r;
  reg  [7:0]  nv_r [0:4];
  reg  [13:0] diag_r;
  reg  [13:0] field_r;
  reg  [13:0] raw_r;
  reg  [13:0] comp_r;
  reg         reload_req_r;
  reg         burn_req_r;
  reg  [1:0]  st_r;
  reg  [2:0]  cnt_r;
  reg         ld_we_r;
  reg  [2:0]  ld_idx_r;
  reg  [13:0] rd_data;
  integer     i;
  genvar      g;

  function addr_ok;
    input [13:0] a;
    begin
      case (a)
        `ADDR_IDLE, `ADDR_ERRORS, `ADDR_FUSE_CTRL,
        `ADDR_ZERO_HI, `ADDR_ZERO_LO, `ADDR_CFG_ONE,
        `ADDR_CFG_TWO, `ADDR_REPAIR, `ADDR_DIAG,
        `ADDR_FIELD, `ADDR_RAW_ANG, `ADDR_TOP_ANG:
          addr_ok = 1'b1;
        default:
          addr_ok = 1'b0; // [RQ27]
      endcase
    end
  endfunction

  function [7:0] nv_default;
    input [2:0] idx;
    begin
      nv_default = (idx == 3'h2) ? `CFG_ONE_RST : 8'h00; // [RQ14]
    end
  endfunction

  // Code zero means no repair, so bit 0 of word 0 cannot be forced
  function [7:0] repair_mask;
    input [1:0] word;
    input [4:0] code;
    begin
      if ((code != 5'h00) && (code[4:3] == word))
        repair_mask = 8'h01 << code[2:0];
      else
        repair_mask = 8'h00;
    end
  endfunction

  spi_frame_rx u_rx (
    .core_clk       (core_clk),
    .srst           (srst),
    .sclk_pin       (sclk_pin),
    .csn_pin        (csn_pin),
    .mosi_pin       (mosi_pin),
    .frame_start_r  (frame_start),
    .sclk_rise_r    (sclk_rise),
    .frame_done_r   (frame_done),
    .frame_len_ok_r (len_ok),
    .frame_word_r   (fw)
  );

  fuse_store u_fuse (
    .core_clk (core_clk),
    .por      (por),
    .we       (st_r == ST_BURN),
    .waddr    (cnt_r),
    .wdata    (nv_r[cnt_r]),
    .raddr    (cnt_r),
    .rdata_r  (fuse_rdata),
    .locked_r (fuse_burned)
  );

  // Frame decode
  wire par_ok    = ~^fw; // [RQ23]
  wire is_cmd    = frame_done & ~expect_data_r;
  wire len_bad   = frame_done & ~len_ok;
  wire par_bad   = frame_done & len_ok & ~par_ok;
  wire good      = frame_done & len_ok & par_ok;
  wire addr_bad  = is_cmd & good & ~addr_ok(fw[13:0]); // [RQ1]
  wire cmd_go    = is_cmd & good & addr_ok(fw[13:0]);
  wire wr_go     = good & expect_data_r; // [RQ24]
  wire [2:0] err_set = {par_bad, addr_bad, len_bad}; // [RQ3]
  wire rd_clear  = pend_r & (resp_addr_r == `ADDR_ERRORS);
  wire [13:0] wr_off = wr_addr_r - `ADDR_ZERO_HI;
  wire nv_hit    = (wr_addr_r >= `ADDR_ZERO_HI) && (wr_addr_r <= `ADDR_REPAIR); // [RQ26]

  // A flag raised in the clearing cycle survives the clear
  always @(posedge core_clk)
  begin
    if (srst)
      err_r <= 3'h0;
    else
      err_r <= (rd_clear ? 3'h0 : err_r) | err_set; // [RQ4]
  end

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      cmd_err_r     <= 1'b0;
      expect_data_r <= 1'b0;
      wr_addr_r     <= `ADDR_IDLE;
      pend_r        <= 1'b0;
      resp_addr_r   <= `ADDR_IDLE;
      resp_r        <= 16'h0000;
    end
    else if (frame_done)
    begin
      cmd_err_r     <= |err_set; // [RQ25]
      expect_data_r <= cmd_go & ~fw[`FRAME_RD_BIT];
      pend_r        <= 1'b1;
      if (cmd_go)
      begin
        resp_addr_r <= fw[13:0];
        wr_addr_r   <= fw[13:0];
      end
      else if (wr_go)
        resp_addr_r <= wr_addr_r;
      else
        resp_addr_r <= `ADDR_IDLE;
    end
    else if (pend_r)
    begin
      // Answer is sampled here and shifted out in the next frame
      pend_r <= 1'b0;
      resp_r <= {^{cmd_err_r, rd_data}, cmd_err_r, rd_data}; // [RQ25]
    end
  end

  // Serial answer; the pin is released between frames
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_shift_r  <= 16'h0000;
      miso_out_r  <= 1'b0;
      miso_oe_n_r <= 1'b1;
    end
    else
    begin
      if (frame_start)
      begin
        tx_shift_r  <= resp_r; // [RQ24]
        miso_oe_n_r <= 1'b0;
      end
      else if (sclk_rise)
      begin
        miso_out_r <= tx_shift_r[15];
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      end
      if (frame_done)
        miso_oe_n_r <= 1'b1;
    end
  end

  // Fuse control bits; reload and burn clear themselves after one cycle
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      otp_access_enable_r <= 1'b0;
      otp_verify_r        <= 1'b0;
      reload_req_r        <= 1'b0;
      burn_req_r          <= 1'b0;
    end
    else if (wr_go && (wr_addr_r == `ADDR_FUSE_CTRL))
    begin
      otp_access_enable_r <= fw[`FUSE_ACCESS_BIT]; // [RQ5]
      otp_verify_r        <= fw[`FUSE_VERIFY_BIT]; // [RQ6]
      reload_req_r        <= fw[`FUSE_RELOAD_BIT]; // [RQ6]
      burn_req_r          <= fw[`FUSE_BURN_BIT] &
                             (fw[`FUSE_ACCESS_BIT] | otp_access_enable_r); // [RQ5]
    end
    else
    begin
      reload_req_r <= 1'b0;
      burn_req_r   <= 1'b0;
    end
  end

  // Reload walks the fuse words after reset; burn walks the soft words in
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      st_r     <= ST_LOAD; // [RQ12]
      cnt_r    <= 3'h0;
      ld_we_r  <= 1'b0;
      ld_idx_r <= 3'h0;
    end
    else
    begin
      ld_we_r  <= (st_r == ST_LOAD);
      ld_idx_r <= cnt_r;
      case (st_r)
        ST_IDLE:
        begin
          cnt_r <= 3'h0;
          if (reload_req_r)
            st_r <= ST_LOAD; // [RQ6]
          else if (burn_req_r && !fuse_burned)
            st_r <= ST_BURN; // [RQ13]
        end
        ST_LOAD, ST_BURN:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == `NV_LAST)
            st_r <= ST_IDLE;
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // Soft values: written freely, replaced by fuse or default contents on reload
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      for (i = 0; i < 5; i = i + 1)
        nv_r[i] <= nv_default(i[2:0]); // [RQ14]
    end
    else if (ld_we_r)
      nv_r[ld_idx_r] <= fuse_burned ? fuse_rdata : nv_default(ld_idx_r); // [RQ13]
    else if (wr_go && nv_hit)
    begin
      if (wr_off[2:0] == `NV_LAST)
        nv_r[wr_off[2:0]] <= {3'h0, fw[4:0]}; // [RQ22]
      else
        nv_r[wr_off[2:0]] <= fw[7:0]; // [RQ12]
    end
  end

  // Effective words after single-bit repair of a burned array
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_eff
      localparam [2:0] WORD_IDX = g;
      reg [7:0] word_r;
      always @(posedge core_clk)
      begin
        if (srst)
          word_r <= nv_default(WORD_IDX);
        else if (fuse_burned)
          word_r <= nv_r[g] | repair_mask(WORD_IDX[1:0], nv_r[4][4:0]); // [RQ22]
        else
          word_r <= nv_r[g];
      end
      assign eff_w[8*g+7:8*g] = word_r;
    end
  endgenerate

  // Sensor core snapshots
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      diag_r  <= `DIAG_RST; // [RQ9]
      field_r <= 14'h0000;
      raw_r   <= 14'h0000;
      comp_r  <= 14'h0000;
    end
    else
    begin
      diag_r  <= {2'h0, gain_value == `GAIN_MAX, gain_value == `GAIN_MIN, // [RQ7]
                  angle_overflow_flag, offset_loops_done, gain_value}; // [RQ8] [RQ9]
      field_r <= magnitude_value;
      raw_r   <= raw_angle; // [RQ10]
      comp_r  <= compensated_angle; // [RQ10]
    end
  end

  // Read side; reads never alter state except clearing the error register
  always @*
  begin
    case (resp_addr_r)
      `ADDR_ERRORS:    rd_data = {11'h000, err_r};
      `ADDR_FUSE_CTRL: rd_data = {7'h00, otp_verify_r, 2'h0, burn_req_r, reload_req_r,
                                  1'b0, otp_access_enable_r};
      `ADDR_ZERO_HI:   rd_data = {6'h00, nv_r[0]};
      `ADDR_ZERO_LO:   rd_data = {6'h00, nv_r[1]};
      `ADDR_CFG_ONE:   rd_data = {6'h00, nv_r[2]};
      `ADDR_CFG_TWO:   rd_data = {6'h00, nv_r[3]};
      `ADDR_REPAIR:    rd_data = {9'h000, nv_r[4][4:0]};
      `ADDR_DIAG:      rd_data = diag_r;
      `ADDR_FIELD:     rd_data = field_r;
      `ADDR_RAW_ANG:   rd_data = raw_r;
      `ADDR_TOP_ANG:   rd_data = nv_r[2][`CFG_TOPSEL_BIT] ? raw_r : comp_r; // [RQ11]
      default:         rd_data = 14'h0000; // [RQ2]
    endcase
  end

  // Settings fanned out to the output generators
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      zero_position_r          <= 14'h0000;
      index_pulse_width_r      <= 2'h1;
      low_noise_trade_r        <= 1'b0;
      rotation_invert_r        <= 1'b0;
      pwm_pin_select_r         <= 1'b0;
      speed_comp_disable_r     <= 1'b0;
      pwm_output_enable_r      <= 1'b0;
      pole_pair_count_r        <= 3'h1;
      dead_band_select_r       <= 2'h3;
      incremental_resolution_r <= 4'hc;
      field_error_flag_r       <= 1'b0;
    end
    else
    begin
      zero_position_r      <= {eff_w[7:0], eff_w[13:8]}; // [RQ15]
      index_pulse_width_r  <= eff_w[16 + `CFG_INDEX_PULSE_WIDTH_BIT] ? 2'h1 : 2'h3; // [RQ17]
      low_noise_trade_r    <= eff_w[16 + `CFG_NOISE_BIT]; // [RQ17]
      rotation_invert_r    <= eff_w[16 + `CFG_DIR_BIT]; // [RQ17]
      pwm_pin_select_r     <= eff_w[16 + `CFG_PWMPIN_BIT]; // [RQ18]
      speed_comp_disable_r <= eff_w[16 + `CFG_SPDDIS_BIT]; // [RQ17]
      pwm_output_enable_r  <= eff_w[16 + `CFG_PWMEN_BIT]; // [RQ18]
      pole_pair_count_r    <= (eff_w[26:24] == 3'h7) ? 3'h7 : eff_w[26:24] + 3'h1; // [RQ19]
      dead_band_select_r   <= ~eff_w[28:27]; // [RQ20]
      case (eff_w[30:29])
        2'h1:    incremental_resolution_r <= 4'hb; // [RQ21]
        2'h2:    incremental_resolution_r <= 4'ha;
        default: incremental_resolution_r <= 4'hc;
      endcase
      // Bit 6 gates the strong-field flag, bit 7 the weak-field flag
      field_error_flag_r <= (diag_r[10] & eff_w[8 + `ZLO_STRONG_BIT]) |
                            (diag_r[11] & eff_w[8 + `ZLO_WEAK_BIT]); // [RQ16]
    end
  end
endmodule // angle_sensor_register_map

// ===== verif/angle_sensor_map_checker.sv
// Purpose: Port-level checks of the angle sensor register map
// Assumes: Sees only top-level ports of the design
// Notes:   Fuse checks use por as their disable, since srst must not touch fuses
`timescale 1ns/1ps
module angle_sensor_map_checker (
  input wire        core_clk,
  input wire        srst,
  input wire        por,
  input wire        csn_pin,
  input wire [7:0]  gain_value,
  input wire        miso_oe_n_r,
  input wire [13:0] zero_position_r,
  input wire [1:0]  index_pulse_width_r,
  input wire [2:0]  pole_pair_count_r,
  input wire [1:0]  dead_band_select_r,
  input wire [3:0]  incremental_resolution_r,
  input wire        field_error_flag_r,
  input wire        otp_access_enable_r,
  input wire        otp_verify_r,
  input wire        fuse_burned
);
  default clocking cb @(posedge core_clk); endclocking
  reset_defaults_a: assert property (
    srst |=> zero_position_r == 14'h0000 && index_pulse_width_r == 2'h1
      && pole_pair_count_r == 3'h1 && dead_band_select_r == 2'h3
      && incremental_resolution_r == 4'hc) else $error("defaults lost in reset");
  reset_fuse_ctrl_a: assert property (
    srst |=> !otp_access_enable_r && !otp_verify_r && miso_oe_n_r)
    else $error("fuse control or drive enable wrong in reset");
  bus_release_a: assert property (
    disable iff (srst) csn_pin [*6] |-> miso_oe_n_r) else $error("miso driven while deselected");
  bus_drive_a: assert property (
    disable iff (srst) !csn_pin [*6] |-> !miso_oe_n_r) else $error("miso not driven in frame");
  width_code_a: assert property (disable iff (srst)
    index_pulse_width_r == 2'h1 || index_pulse_width_r == 2'h3) else $error("bad index width");
  pole_range_a: assert property (disable iff (srst)
    pole_pair_count_r != 3'h0) else $error("pole pair count zero");
  res_range_a: assert property (disable iff (srst)
    incremental_resolution_r >= 4'ha && incremental_resolution_r <= 4'hc)
    else $error("resolution outside ten to twelve");
  field_quiet_a: assert property (
    disable iff (srst) (gain_value != 8'hff && gain_value != 8'h00) [*5] |-> !field_error_flag_r)
    else $error("field error without extreme gain");
  fuse_keep_a: assert property (
    disable iff (por) fuse_burned |=> fuse_burned) else $error("burned fuses lost");
  burn_gate_a: assert property (
    disable iff (por) $rose(fuse_burned) |-> otp_access_enable_r) else $error("burn without access");
  cover property ($rose(fuse_burned));
  cover property (field_error_flag_r);
  cover property (pole_pair_count_r == 3'h7);
  cover property (otp_verify_r);
endmodule // angle_sensor_map_checker
bind angle_sensor_register_map angle_sensor_map_checker chk (
  .core_clk(core_clk), .srst(srst), .por(por), .csn_pin(csn_pin), .gain_value(gain_value),
  .miso_oe_n_r(miso_oe_n_r), .zero_position_r(zero_position_r),
  .index_pulse_width_r(index_pulse_width_r), .pole_pair_count_r(pole_pair_count_r),
  .dead_band_select_r(dead_band_select_r), .incremental_resolution_r(incremental_resolution_r),
  .field_error_flag_r(field_error_flag_r), .otp_access_enable_r(otp_access_enable_r),
  .otp_verify_r(otp_verify_r), .fuse_burned(fuse_burned));

// ===== verif/spi_host_model.sv
// Purpose: Host acting as serial master in mode 1
// Assumes: Serial clock period of eight core cycles
// Notes:   Answer bits sampled late, just before the next rise, for margin
`timescale 1ns/1ps
module spi_host_model (
  input  wire core_clk,
  input  wire miso,
  output reg  sclk,
  output reg  csn,
  output reg  mosi
);
  initial
  begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input [15:0] tx, input int n, output [15:0] rx);
    rx = 16'h0000;
    @(posedge core_clk);
    csn <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      mosi <= tx[15 - i];
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
      rx = {rx[14:0], miso};
    end
    csn  <= 1'b1;
    // Released line shows the inverse so a stale bit can never pass
    mosi <= ~mosi;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // spi_host_model

// ===== verif/angle_sensor_register_map_test.sv
// Purpose: Self-checking bench for the register map
// Assumes: Blank fuses at start via por
// Notes:   Every scenario is a task that judges its own results
`timescale 1ns/1ps
module angle_sensor_register_map_test;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg         por = 1'b1;
  reg  [13:0] raw_angle = 14'h1234;
  reg  [13:0] compensated_angle = 14'h2abc;
  reg  [13:0] magnitude_value = 14'h0f0f;
  reg  [7:0]  gain_value = 8'h80;
  reg         angle_overflow_flag = 1'b0;
  reg         offset_loops_done = 1'b1;
  wire        sclk, csn, mosi, miso_out_r, miso_oe_n_r, miso_line;
  wire [13:0] zero_position_r;
  wire [1:0]  index_pulse_width_r, dead_band_select_r;
  wire        low_noise_trade_r, rotation_invert_r, pwm_pin_select_r, speed_comp_disable_r;
  wire        pwm_output_enable_r, field_error_flag_r, otp_access_enable_r, otp_verify_r;
  wire        fuse_burned;
  wire [2:0]  pole_pair_count_r;
  wire [3:0]  incremental_resolution_r;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  reg  [15:0] d;

  always #50 core_clk = ~core_clk;
  assign miso_line = miso_oe_n_r ? ~miso_out_r : miso_out_r;

  angle_sensor_register_map dut (.core_clk(core_clk), .srst(srst), .por(por),
    .sclk_pin(sclk), .csn_pin(csn), .mosi_pin(mosi), .raw_angle(raw_angle),
    .compensated_angle(compensated_angle), .magnitude_value(magnitude_value),
    .gain_value(gain_value), .angle_overflow_flag(angle_overflow_flag),
    .offset_loops_done(offset_loops_done), .miso_out_r(miso_out_r), .miso_oe_n_r(miso_oe_n_r),
    .zero_position_r(zero_position_r), .index_pulse_width_r(index_pulse_width_r),
    .low_noise_trade_r(low_noise_trade_r), .rotation_invert_r(rotation_invert_r),
    .pwm_pin_select_r(pwm_pin_select_r), .speed_comp_disable_r(speed_comp_disable_r),
    .pwm_output_enable_r(pwm_output_enable_r), .pole_pair_count_r(pole_pair_count_r),
    .dead_band_select_r(dead_band_select_r), .incremental_resolution_r(incremental_resolution_r),
    .field_error_flag_r(field_error_flag_r), .otp_access_enable_r(otp_access_enable_r),
    .otp_verify_r(otp_verify_r), .fuse_burned(fuse_burned));
  spi_host_model host (.core_clk(core_clk), .miso(miso_line), .sclk(sclk), .csn(csn),
    .mosi(mosi));

  function [15:0] frm(input rd, input [13:0] a);
    frm = {^{rd, a}, rd, a};
  endfunction
  task chk_word(input [15:0] got, input [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_out(input [13:0] got, input [13:0] exp);
    chk_word({2'b00, got}, {2'b00, exp});
  endtask
  task rd(input [13:0] a, output [15:0] r);
    host.xfer(frm(1'b1, a), 16, r);
    host.xfer(frm(1'b1, 14'h0000), 16, r);
  endtask
  task wr(input [13:0] a, input [7:0] v);
    reg [15:0] r;
    host.xfer(frm(1'b0, a), 16, r);
    host.xfer(frm(1'b0, {6'h00, v}), 16, r);
    repeat (4) @(posedge core_clk);
  endtask
  task t_angles;
    rd(14'h3ffe, d); chk_word(d, frm(1'b0, raw_angle));
    rd(14'h3fff, d); chk_word(d, frm(1'b0, compensated_angle));
    rd(14'h3ffd, d); chk_word(d, frm(1'b0, magnitude_value));
    wr(14'h3ffe, 8'h55);
    rd(14'h3ffe, d); chk_word(d, frm(1'b0, raw_angle));
    rd(14'h0001, d); chk_word(d, frm(1'b0, 14'h0000));
    wr(14'h0018, 8'h41);
    rd(14'h3fff, d); chk_word(d, frm(1'b0, raw_angle));
    wr(14'h0018, 8'h01);
    $display("test angles done");
  endtask
  task diag(input [7:0] g, input c, input l, input f, input [13:0] e);
    @(posedge core_clk);
    gain_value <= g;
    angle_overflow_flag <= c;
    offset_loops_done <= l;
    rd(14'h3ffc, d); chk_word(d, frm(1'b0, e));
    chk_out({13'h0, field_error_flag_r}, {13'h0, f});
  endtask
  task t_diag;
    wr(14'h0017, 8'h80);
    diag(8'h80, 1'b0, 1'b1, 1'b0, 14'h0180);
    diag(8'hff, 1'b0, 1'b1, 1'b1, 14'h09ff);
    diag(8'h00, 1'b1, 1'b0, 1'b0, 14'h0600);
    diag(8'h40, 1'b1, 1'b1, 1'b0, 14'h0340);
    wr(14'h0017, 8'h40);
    diag(8'h00, 1'b0, 1'b1, 1'b1, 14'h0500);
    diag(8'h80, 1'b0, 1'b1, 1'b0, 14'h0180);
    $display("test diagnostics done");
  endtask
  task err(input [15:0] f, input integer n, input [13:0] flg);
    host.xfer(f, n, d);
    host.xfer(frm(1'b1, 14'h0000), 16, d); chk_word(d, 16'hc000);
    host.xfer(frm(1'b1, 14'h0001), 16, d); chk_word(d, frm(1'b0, 14'h0000));
    host.xfer(frm(1'b1, 14'h0000), 16, d); chk_word(d, frm(1'b0, flg));
    rd(14'h0001, d); chk_word(d, frm(1'b0, 14'h0000));
  endtask
  task t_errors;
    err(frm(1'b1, 14'h3ffe) ^ 16'h8000, 16, 14'h0004);
    err(frm(1'b1, 14'h0002), 16, 14'h0002);
    err(16'hc000, 8, 14'h0001);
    $display("test errors done");
  endtask
  task t_config;
    rd(14'h0018, d); chk_word(d, frm(1'b0, 14'h0001));
    wr(14'h0016, 8'ha5);
    wr(14'h0017, 8'h3c);
    chk_out(zero_position_r, {8'ha5, 6'h3c});
    rd(14'h0016, d); chk_word(d, frm(1'b0, 14'h00a5));
    wr(14'h0018, 8'h9e);
    chk_out({7'h0, index_pulse_width_r, low_noise_trade_r, rotation_invert_r, pwm_pin_select_r,
      speed_comp_disable_r, pwm_output_enable_r}, 14'h007f);
    wr(14'h0018, 8'h01);
    chk_out({7'h0, index_pulse_width_r, low_noise_trade_r, rotation_invert_r, pwm_pin_select_r,
      speed_comp_disable_r, pwm_output_enable_r}, 14'h0020);
    for (int i = 0; i < 8; i++)
    begin
      wr(14'h0019, {1'b0, 2'(i % 3), 2'(i), 3'(i)});
      chk_out({5'h0, incremental_resolution_r, dead_band_select_r, pole_pair_count_r},
        {5'h0, 4'(12 - i % 3), 2'(3 - i), 3'(i == 7 ? 7 : i + 1)});
    end
    $display("test settings done");
  endtask
  task t_fuse;
    wr(14'h0016, 8'h5a);
    wr(14'h0019, 8'h00);
    wr(14'h0003, 8'h09);
    chk_out({12'h0, fuse_burned, otp_access_enable_r}, 14'h0003);
    wr(14'h0016, 8'h11);
    chk_out({6'h0, zero_position_r[13:6]}, 14'h0011);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk_out({6'h0, zero_position_r[13:6]}, 14'h005a);
    wr(14'h0016, 8'h22);
    wr(14'h0003, 8'h09);
    wr(14'h0003, 8'h04);
    chk_out({6'h0, zero_position_r[13:6]}, 14'h005a);
    wr(14'h0003, 8'h41);
    chk_out({12'h0, otp_verify_r, otp_access_enable_r}, 14'h0003);
    wr(14'h001a, 8'h1a);
    chk_out({11'h0, pole_pair_count_r}, 14'h0005);
    $display("test fuses done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    por <= 1'b0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    repeat (12) @(posedge core_clk);
    t_angles;
    t_diag;
    t_errors;
    t_config;
    t_fuse;
    final_report;
  end
  // About 100 frames of some 150 cycles each; allow three times that
  initial
  begin
    #5000000;
    error_cnt = error_cnt + 1;
    $display("FAIL %0t watchdog expired", $time);
    final_report;
  end
endmodule // angle_sensor_register_map_test
